/* hw/mac_slice.sv */
// Multiply-accumulate slice with operand registers, reached over APB
//
// How it works
// - One clock, pclk, drives operand, pipeline and accumulator registers.
// - Slice enable 1 updates slice registers, 0 freezes them; resets enabled.
// - A and B captured in own registers, feeding the multiplier; reset to zero.
// - C and D captured in own registers, feeding only the adder; reset zero.
// - Top clear zeroes A, C and the upper multiplier pipeline half.
// - Bottom clear zeroes B, D, lower pipeline half and product register.
// - Result is full 32-bit product or two 16-bit halves in split mode.
// - Upper accumulator freeze holds bits 31:16; default updates.
// - Upper accumulator clear zeroes bits 31:16; default leaves them.
// - Accumulator is one 32-bit or two independent 16-bit accumulators.
`timescale 1ns/100ps

module mac_slice
    import mac_slice_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Slice result
    output logic      [31:0] slice_result
);
    import mac_slice_pkg::*;

    // Multiplier: full 16x16, or two 8x8 products side by side
    function automatic logic [31:0] multiply(input logic [15:0] x,
                                             input logic [15:0] y,
                                             input logic        split);
        logic [15:0] upper;
        logic [15:0] lower;
        upper = {8'h00, x[15:8]} * {8'h00, y[15:8]};
        lower = {8'h00, x[7:0]} * {8'h00, y[7:0]};
        if (split) begin
            multiply = {upper, lower};
        end else begin
            multiply = {16'h0000, x} * {16'h0000, y};
        end
    endfunction : multiply

    // Adder: one 32-bit sum, or two 16-bit sums with no carry between
    function automatic logic [31:0] add(input logic [31:0] x,
                                        input logic [31:0] y,
                                        input logic        split);
        logic [15:0] upper;
        logic [15:0] lower;
        upper = x[31:16] + y[31:16];
        lower = x[15:0] + y[15:0];
        if (split) begin
            add = {upper, lower};
        end else begin
            add = x + y;
        end
    endfunction : add

    // Register file and bus state
    ctrl_t       ctrl;
    ctrl_t       next_ctrl;
    logic [31:0] operand_ab;
    logic [31:0] next_operand_ab;
    logic [31:0] operand_cd;
    logic [31:0] next_operand_cd;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // Slice state
    operands_t   operands;
    operands_t   next_operands;
    logic [31:0] stage;
    logic [31:0] next_stage;
    logic [31:0] product;
    logic [31:0] next_product;
    logic [31:0] next_slice_result;

    logic        access;
    logic        write_done;
    logic        mapped;

    assign access     = psel && penable;
    assign write_done = access && pready && pwrite && !pslverr;
    assign mapped     = (paddr == CTRL_OFFSET) || (paddr == OPERAND_AB_OFFSET) ||
                        (paddr == OPERAND_CD_OFFSET) || (paddr == RESULT_OFFSET);

    // Bus answer: one wait cycle, then pready with data and error flag
    always_comb begin
        next_pready  = access && !pready;
        next_pslverr = access && !pready && !mapped;
        next_prdata  = WORD_RESET;
        if (access && !pready && !pwrite) begin
            unique case (paddr)
                CTRL_OFFSET:       next_prdata = {21'h00_0000, ctrl};
                OPERAND_AB_OFFSET: next_prdata = operand_ab;
                OPERAND_CD_OFFSET: next_prdata = operand_cd;
                RESULT_OFFSET:     next_prdata = slice_result;
                default:           next_prdata = WORD_RESET;
            endcase
        end
    end

    // Register writes land on the edge that completes the access
    always_comb begin
        next_ctrl       = ctrl;
        next_operand_ab = operand_ab;
        next_operand_cd = operand_cd;
        if (write_done) begin
            unique case (paddr)
                CTRL_OFFSET:       next_ctrl       = ctrl_t'(pwdata[10:0]);
                OPERAND_AB_OFFSET: next_operand_ab = pwdata;
                OPERAND_CD_OFFSET: next_operand_cd = pwdata;
                default:           next_ctrl       = ctrl;  // Result is read only
            endcase
        end
    end

    // Bus side registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= ctrl_t'(CTRL_RESET);
            operand_ab <= WORD_RESET;
            operand_cd <= WORD_RESET;
            prdata     <= WORD_RESET;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            operand_ab <= next_operand_ab;
            operand_cd <= next_operand_cd;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
        end
    end

    // Operand capture with per-register freeze and half clears
    always_comb begin
        next_operands = operands;
        if (ctrl.slice_clock_enable) begin
            if (!ctrl.operand_a_freeze) begin
                next_operands.a = operand_ab[LOW_OPERAND_LSB +: 16];
            end
            if (!ctrl.operand_b_freeze) begin
                next_operands.b = operand_ab[HIGH_OPERAND_LSB +: 16];
            end
            if (!ctrl.operand_c_freeze) begin
                next_operands.c = operand_cd[LOW_OPERAND_LSB +: 16];
            end
            if (!ctrl.operand_d_freeze) begin
                next_operands.d = operand_cd[HIGH_OPERAND_LSB +: 16];
            end
            if (ctrl.top_input_clear) begin
                next_operands.a = OPERAND_RESET;
                next_operands.c = OPERAND_RESET;
            end
            if (ctrl.bottom_input_clear) begin
                next_operands.b = OPERAND_RESET;
                next_operands.d = OPERAND_RESET;
            end
        end
    end

    // Multiplier pipeline: stage halves, then product register
    always_comb begin
        next_stage   = stage;
        next_product = product;
        if (ctrl.slice_clock_enable) begin
            next_stage   = multiply(operands.a, operands.b, ctrl.split_mode);
            next_product = stage;
            if (ctrl.top_input_clear) begin
                next_stage[31:16] = OPERAND_RESET;
            end
            if (ctrl.bottom_input_clear) begin
                next_stage[15:0] = OPERAND_RESET;
                next_product     = WORD_RESET;
            end
        end
    end

    // Accumulator: product plus C and D, with upper half freeze and clear
    always_comb begin
        logic [31:0] base;
        logic [31:0] sum;
        base = ctrl.accumulate ? slice_result : WORD_RESET;
        sum  = add(add(base, product, ctrl.split_mode),
                   {operands.c, operands.d}, ctrl.split_mode);
        next_slice_result = slice_result;
        if (ctrl.slice_clock_enable) begin
            next_slice_result = sum;
            if (ctrl.upper_acc_freeze) begin
                next_slice_result[31:16] = slice_result[31:16];
            end
            if (ctrl.upper_acc_clear) begin
                next_slice_result[31:16] = OPERAND_RESET;
            end
        end
    end

    // Slice registers, all on the one slice clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operands     <= '0;
            stage        <= WORD_RESET;
            product      <= WORD_RESET;
            slice_result <= WORD_RESET;
        end else begin
            operands     <= next_operands;
            stage        <= next_stage;
            product      <= next_product;
            slice_result <= next_slice_result;
        end
    end

endmodule : mac_slice

/* hw/mac_slice_pkg.sv */
// Shared constants and types of the multiply-accumulate slice
package mac_slice_pkg;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
    localparam logic [7:0]  OPERAND_AB_OFFSET = 8'h04;
    localparam logic [7:0]  OPERAND_CD_OFFSET = 8'h08;
    localparam logic [7:0]  RESULT_OFFSET     = 8'h0C;

    // Operand word layout: low half carries A or C, high half B or D
    localparam int          LOW_OPERAND_LSB   = 0;
    localparam int          HIGH_OPERAND_LSB  = 16;

    // Reset values
    localparam logic [15:0] OPERAND_RESET     = 16'h0000;
    localparam logic [31:0] WORD_RESET        = 32'h0000_0000;
    localparam logic [10:0] CTRL_RESET        = 11'h001;

    // Control register, bit 0 upward: enable, four operand freezes,
    // top and bottom input clears, upper accumulator freeze and clear,
    // split mode, accumulate mode
    typedef struct packed {
        logic accumulate;
        logic split_mode;
        logic upper_acc_clear;
        logic upper_acc_freeze;
        logic bottom_input_clear;
        logic top_input_clear;
        logic operand_d_freeze;
        logic operand_c_freeze;
        logic operand_b_freeze;
        logic operand_a_freeze;
        logic slice_clock_enable;
    } ctrl_t;

    // Operand input registers of the slice
    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
        logic [15:0] d;
    } operands_t;

endpackage : mac_slice_pkg

/* tb/mac_slice_checker.sv */
// Port assertions for the multiply-accumulate slice
`timescale 1ns/100ps
module mac_slice_checker
    import mac_slice_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB and result
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] slice_result
);
    logic en_q;
    logic hold_q;
    logic clr_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Mirror of enable, upper freeze and upper clear as last written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {clr_q, hold_q, en_q} <= 3'b001;
        end else if (pready && pwrite && paddr == CTRL_OFFSET) begin
            {clr_q, hold_q, en_q} <= {pwdata[8:7], pwdata[0]};
        end
    end
    sequence access_wait;
        psel && penable && !pready;
    endsequence
    sequence read_of(logic [7:0] addr);
        pready && !pwrite && paddr == addr;
    endsequence
    answer_time_a: assert property (access_wait |=> pready) else $error("late answer");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    error_with_ready_a: assert property (pslverr |-> pready && psel) else $error("stray error");
    unmapped_error_a: assert property (pready && paddr > RESULT_OFFSET |-> pslverr)
        else $error("unmapped not refused");
    write_data_zero_a: assert property (pready && pwrite |-> prdata == WORD_RESET)
        else $error("read data on write");
    ctrl_spare_a: assert property (read_of(CTRL_OFFSET) |-> prdata[31:11] == 21'h0)
        else $error("spare control bits set");
    frozen_slice_a: assert property (!en_q |=> $stable(slice_result))
        else $error("result moved while disabled");
    upper_clear_a: assert property (en_q && clr_q |=> slice_result[31:16] == 16'h0)
        else $error("upper half not cleared");
    upper_hold_a: assert property (en_q && hold_q && !clr_q |=> $stable(slice_result[31:16]))
        else $error("upper half not held");
endmodule : mac_slice_checker

/* tb/apb_fabric_master.sv */
// APB master standing for the fabric logic that drives the slice
`timescale 1ns/100ps
module apb_fabric_master
(
    // Clock
    input  wire logic        pclk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Idle bus from time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // One transfer: setup, access held until ready, then release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait that never sees ready
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d}; // Released lines stop showing data
    endtask : xfer
endmodule : apb_fabric_master

/* tb/mac_slice_tb.sv */
// Self-checking bench of the multiply-accumulate slice
`timescale 1ns/100ps
module mac_slice_tb;
    import mac_slice_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, slice_result, rdat, keep;
    logic [15:0] op [4];
    logic [15:0] nw [4];
    int          mismatches, total_checks, seed;
    mac_slice u_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slice_result(slice_result));
    apb_fabric_master u_apb(.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #1_000_000;
        mismatches++;
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        u_apb.xfer(1'b1, ad, dt, rdat, err);
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        u_apb.xfer(1'b0, ad, 32'h0000_0000, rdat, err);
        chk(rdat, exp);
    endtask : rd
    // Control word, new operands, then settle through the pipeline
    task automatic load(input logic [31:0] ctl);
        wr(CTRL_OFFSET, ctl);
        wr(OPERAND_AB_OFFSET, {nw[1], nw[0]});
        wr(OPERAND_CD_OFFSET, {nw[3], nw[2]});
        repeat (6) @(posedge pclk);
    endtask : load
    // Expected result: whole product or two byte products, C above D
    function automatic logic [31:0] model(input logic sp);
        if (!sp) return op[0] * op[1] + {op[2], op[3]};
        return {16'(op[0][15:8] * op[1][15:8] + op[2]), 16'(op[0][7:0] * op[1][7:0] + op[3])};
    endfunction : model
    // Main sequence
    initial begin
        presetn = 1'b0;
        seed = 32'hc08b_6066;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(CTRL_OFFSET, 32'h0000_0001);
        rd(RESULT_OFFSET, WORD_RESET);
        for (int i = 0; i < 8; i++) begin
            for (int j = 0; j < 4; j++) nw[j] = (i < 2) ? 16'hffff : 16'($random(seed));
            op = nw;
            load(32'h0000_0001 | (32'(i % 2) << 9));
            rd(RESULT_OFFSET, model(i % 2));
            chk(slice_result, model(i % 2));
        end
        // Split accumulate for four edges: each half grows with no carry between halves
        keep = model(1'b1);
        wr(CTRL_OFFSET, 32'h0000_0601);
        wr(CTRL_OFFSET, 32'h0000_0200);
        rd(RESULT_OFFSET, {16'(keep[31:16] * 5), 16'(keep[15:0] * 5)});
        // Each freeze keeps its own operand only
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 4; j++) nw[j] = 16'($random(seed));
            load(32'h0000_0001 | (32'h0000_0002 << k));
            for (int j = 0; j < 4; j++) if (j != k) op[j] = nw[j];
            rd(RESULT_OFFSET, model(1'b0));
        end
        op = nw;
        wr(CTRL_OFFSET, 32'h0000_0021);
        repeat (6) @(posedge pclk);
        rd(RESULT_OFFSET, {16'h0000, op[3]});
        wr(CTRL_OFFSET, 32'h0000_0041);
        repeat (6) @(posedge pclk);
        rd(RESULT_OFFSET, {op[2], 16'h0000});
        // Disabled slice ignores new operands
        for (int j = 0; j < 4; j++) nw[j] = 16'($random(seed));
        keep = slice_result;
        load(32'h0000_0000);
        rd(RESULT_OFFSET, keep);
        // Accumulate with upper clear, then upper freeze
        wr(CTRL_OFFSET, 32'h0000_0501);
        repeat (3) @(posedge pclk);
        chk({16'h0000, slice_result[31:16]}, 32'h0000_0000);
        wr(CTRL_OFFSET, 32'h0000_0401);
        repeat (4) @(posedge pclk);
        wr(CTRL_OFFSET, 32'h0000_0481);
        repeat (2) @(posedge pclk);
        keep = slice_result;
        repeat (5) @(posedge pclk);
        chk({16'h0000, slice_result[31:16]}, {16'h0000, keep[31:16]});
        wr(8'h10, 32'h1234_5678);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        wr(RESULT_OFFSET, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0000);
        chk({16'h0000, slice_result[31:16]}, {16'h0000, keep[31:16]});
        report_and_stop();
    end
endmodule : mac_slice_tb
bind mac_slice mac_slice_checker u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slice_result(slice_result));
